// ===== design/csav_agen.sv
// effective address and vector slot address generator
`timescale 1ns/1ps
module csav_agen
  import csav_pkg::*;
(
  csav_core_if.agen bus
);
  always_comb begin
    unique case (bus.agMode)
      AG_IDX_X: bus.agAddr = bus.agOpnd + {8'h00, bus.agX};
      AG_IDX_Y: bus.agAddr = bus.agOpnd + {8'h00, bus.agY};
      AG_DIRECT: bus.agAddr = {7'h00, bus.agPage, bus.agOpnd[7:0]};
      // slot 15 lowest, each lower slot two bytes higher
      AG_TABLE: bus.agAddr = TABLE_CALL_BASE + {11'h000, ~bus.agSlot, 1'b0};
      AG_VEC: bus.agAddr = IRQ_VEC_BASE + {11'h000, bus.agSlot, 1'b0};
      AG_PAGE_CALL: bus.agAddr = {PAGE_CALL_PAGE, bus.agOpnd[7:0]};
      default: bus.agAddr = bus.agOpnd;
    endcase
  end
endmodule

// ===== design/csav_alu.sv
// eight-bit alu with carry, half-carry, overflow, zero and sign
`timescale 1ns/1ps
module csav_alu
  import csav_pkg::*;
(
  csav_core_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] r;
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    r = 8'h00;
    bus.aluC = bus.aluCin;
    bus.aluH = 1'b0;
    bus.aluV = 1'b0;
    unique case (bus.aluOp)
      ALU_ADD: begin
        sum = {1'b0, bus.aluA} + {1'b0, bus.aluB} + {8'h00, bus.aluCin};
        nib = {1'b0, bus.aluA[3:0]} + {1'b0, bus.aluB[3:0]}
          + {4'h0, bus.aluCin};
        r = sum[7:0];
        bus.aluC = sum[8];
        bus.aluH = nib[4];
        bus.aluV = (bus.aluA[7] == bus.aluB[7]) && (r[7] != bus.aluA[7]);
      end
      ALU_SUB: begin
        // carry clear means a borrow was taken
        sum = {1'b0, bus.aluA} - {1'b0, bus.aluB} - {8'h00, ~bus.aluCin};
        nib = {1'b0, bus.aluA[3:0]} - {1'b0, bus.aluB[3:0]}
          - {4'h0, ~bus.aluCin};
        r = sum[7:0];
        bus.aluC = ~sum[8];
        bus.aluH = ~nib[4];
        bus.aluV = (bus.aluA[7] != bus.aluB[7]) && (r[7] != bus.aluA[7]);
      end
      ALU_SHL: begin
        r = {bus.aluA[6:0], 1'b0};
        bus.aluC = bus.aluA[7];
      end
      ALU_ROL: begin
        r = {bus.aluA[6:0], bus.aluCin};
        bus.aluC = bus.aluA[7];
      end
      ALU_PASS: r = bus.aluB;
      ALU_BIT: begin
        r = bus.aluA & bus.aluB;
        bus.aluV = bus.aluB[6];
      end
      default: r = 8'h00;
    endcase
    bus.aluRes = r;
    bus.aluZ = (r == 8'h00);
    bus.aluN = (bus.aluOp == ALU_BIT) ? bus.aluB[7] : r[7];
  end
endmodule

// ===== design/csav_core.sv
// cpu architectural state with apb access and memory vectoring
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module csav_core
  import csav_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] progAddr,
  output logic progRd,
  input wire logic [7:0] progRdData,
  output logic [8:0] dataAddr,
  output logic dataRd,
  output logic dataWr,
  output logic [7:0] dataWrData,
  input wire logic [7:0] dataRdData
);
  typedef enum logic [2:0] {
    ST_BOOT, ST_IDLE, ST_FLO, ST_FHI, ST_FWT, ST_PSH, ST_PRD, ST_PWT
  } csav_state_t;

  csav_state_t state_r;
  logic [7:0] acc_r, x_r, y_r, stackPtr_r, flags_r, flagsNxt, fetchLo_r;
  logic [15:0] pc_r, opnd_r, ea_r, progAddr_r, wideAccPair;
  logic [8:0] dataAddr_r;
  logic [7:0] dataWrData_r, opLow;
  logic [3:0] opSlot;
  logic progRd_r, dataRd_r, dataWr_r, pageFlag;
  logic [31:0] prdata_r, rdMux;
  logic pready_r, pslverr_r, hit, busy, setup, regWr, cmdGo, irqTake;
  logic vecCmd;
  csav_cmd_t cmdIn;

  csav_core_if cif();
  csav_alu u_alu (.bus(cif));
  csav_agen u_agen (.bus(cif));

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign progAddr = progAddr_r;
  assign progRd = progRd_r;
  assign dataAddr = dataAddr_r;
  assign dataRd = dataRd_r;
  assign dataWr = dataWr_r;
  assign dataWrData = dataWrData_r;

  assign busy = (state_r != ST_IDLE);
  assign setup = psel && !penable;
  assign regWr = psel && penable && pready_r && pwrite && !pslverr_r;
  assign cmdIn = csav_cmd_t'(pwdata[4:0]);
  assign cmdGo = regWr && (paddr == OFF_CMD);
  assign irqTake = (cmdIn == CMD_IRQ) && flags_r[FLG_I];
  assign vecCmd = (cmdIn == CMD_RSTV) || (cmdIn == CMD_SW_BREAK)
    || (cmdIn == CMD_TABLE_CALL) || irqTake;
  assign wideAccPair = {y_r, acc_r};
  assign opLow = opnd_r[7:0];
  assign opSlot = opnd_r[3:0];
  assign pageFlag = flags_r[FLG_G];

  //////////////////////////////////////////////////////////////////////////
  // alu and address generator operands
  assign cif.aluA = acc_r;
  assign cif.aluB = opLow;
  assign cif.aluCin = flags_r[FLG_C];
  assign cif.agOpnd = opnd_r;
  assign cif.agX = x_r;
  assign cif.agY = y_r;
  assign cif.agPage = pageFlag;

  always_comb begin
    unique case (cmdIn)
      CMD_ADD: cif.aluOp = ALU_ADD;
      CMD_SUB: cif.aluOp = ALU_SUB;
      CMD_SHL: cif.aluOp = ALU_SHL;
      CMD_ROL: cif.aluOp = ALU_ROL;
      CMD_BIT: cif.aluOp = ALU_BIT;
      default: cif.aluOp = ALU_PASS;
    endcase
  end

  always_comb begin
    cif.agSlot = opSlot;
    unique case (cmdIn)
      CMD_IDXX: cif.agMode = AG_IDX_X;
      CMD_IDXY: cif.agMode = AG_IDX_Y;
      CMD_TABLE_CALL: cif.agMode = AG_TABLE;
      CMD_SW_BREAK: begin
        // break shares the vector of table call slot 0
        cif.agMode = AG_TABLE;
        cif.agSlot = SW_BREAK_SLOT;
      end
      CMD_IRQ: cif.agMode = AG_VEC;
      CMD_RSTV: begin
        cif.agMode = AG_VEC;
        cif.agSlot = RESET_SLOT;
      end
      CMD_PAGE_CALL: cif.agMode = AG_PAGE_CALL;
      default: cif.agMode = AG_DIRECT;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      OFF_ACC: rdMux = {24'h000000, acc_r};
      OFF_X: rdMux = {24'h000000, x_r};
      OFF_Y: rdMux = {24'h000000, y_r};
      OFF_STACK_PTR: rdMux = {24'h000000, stackPtr_r};
      OFF_FLAGS: rdMux = {24'h000000, flags_r};
      OFF_PC: rdMux = {16'h0000, pc_r};
      OFF_CMD: rdMux = {31'h00000000, busy};
      OFF_OPND: rdMux = {16'h0000, opnd_r};
      OFF_EA: rdMux = {16'h0000, ea_r};
      OFF_WIDE_PAIR: rdMux = {16'h0000, wideAccPair};
      default: begin
        rdMux = 32'h00000000;
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (setup) begin
      pready_r <= 1'b1;
      prdata_r <= pwrite ? 32'h00000000 : rdMux;
      // writes refused while a sequence runs, and to the address result
      pslverr_r <= !hit || (pwrite && (busy || paddr == OFF_EA));
    end else if (psel && penable) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // memory sequencer; the program port has no write strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_BOOT;
      progAddr_r <= PC_FIRST;
      progRd_r <= 1'b0;
      fetchLo_r <= 8'h00;
      dataAddr_r <= 9'h000;
      dataRd_r <= 1'b0;
      dataWr_r <= 1'b0;
      dataWrData_r <= 8'h00;
    end else begin
      unique case (state_r)
        ST_BOOT: begin
          progAddr_r <= RESET_VEC_LO;
          progRd_r <= 1'b1;
          state_r <= ST_FLO;
        end
        ST_IDLE: begin
          if (cmdGo && vecCmd) begin
            progAddr_r <= cif.agAddr;
            progRd_r <= 1'b1;
            state_r <= ST_FLO;
          end else if (cmdGo && cmdIn == CMD_PUSH) begin
            dataAddr_r <= {STACK_PAGE, stackPtr_r};
            dataWrData_r <= acc_r;
            dataWr_r <= 1'b1;
            state_r <= ST_PSH;
          end else if (cmdGo && cmdIn == CMD_POP) begin
            dataAddr_r <= {STACK_PAGE, stackPtr_r + 8'h01};
            dataRd_r <= 1'b1;
            state_r <= ST_PRD;
          end
        end
        ST_FLO: begin
          progAddr_r <= progAddr_r + 16'h0001;
          state_r <= ST_FHI;
        end
        ST_FHI: begin
          progRd_r <= 1'b0;
          fetchLo_r <= progRdData;
          state_r <= ST_FWT;
        end
        ST_FWT: state_r <= ST_IDLE;
        ST_PSH: begin
          dataWr_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        ST_PRD: begin
          dataRd_r <= 1'b0;
          state_r <= ST_PWT;
        end
        ST_PWT: state_r <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // program counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_r <= PC_FIRST;
    end else if (state_r == ST_FWT) begin
      pc_r <= {progRdData, fetchLo_r};
    end else if (regWr && paddr == OFF_PC) begin
      pc_r <= pwdata[15:0];
    end else if (cmdGo && cmdIn == CMD_PAGE_CALL) begin
      pc_r <= cif.agAddr;
    end else if (cmdGo && cmdIn == CMD_INCPC) begin
      pc_r <= pc_r + 16'h0001;
    end
  end

  // stack pointer is left without reset on purpose
  always_ff @(posedge clk) begin
    if (regWr && paddr == OFF_STACK_PTR) begin
      stackPtr_r <= pwdata[7:0];
    end else if (state_r == ST_PSH) begin
      stackPtr_r <= stackPtr_r - 8'h01;
    end else if (cmdGo && cmdIn == CMD_POP) begin
      stackPtr_r <= stackPtr_r + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // accumulator, index registers, operand and address result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= 8'h00;
    end else if (regWr && (paddr == OFF_ACC || paddr == OFF_WIDE_PAIR)) begin
      acc_r <= pwdata[7:0];
    end else if (state_r == ST_PWT) begin
      acc_r <= dataRdData;
    end else if (cmdGo && cmdIn == CMD_INCYA) begin
      acc_r <= wideAccPair[7:0] + 8'h01;
    end else if (cmdGo && (cmdIn == CMD_ADD || cmdIn == CMD_SUB
        || cmdIn == CMD_SHL || cmdIn == CMD_ROL || cmdIn == CMD_LDA)) begin
      acc_r <= cif.aluRes;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      y_r <= 8'h00;
    end else if (regWr && paddr == OFF_Y) begin
      y_r <= pwdata[7:0];
    end else if (regWr && paddr == OFF_WIDE_PAIR) begin
      y_r <= pwdata[15:8];
    end else if (cmdGo && cmdIn == CMD_INCYA && acc_r == 8'hff) begin
      y_r <= y_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      x_r <= 8'h00;
    end else if (regWr && paddr == OFF_X) begin
      x_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opnd_r <= 16'h0000;
    end else if (regWr && paddr == OFF_OPND) begin
      opnd_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ea_r <= 16'h0000;
    end else if (cmdGo && (cmdIn == CMD_IDXX || cmdIn == CMD_IDXY
        || cmdIn == CMD_DIRECT)) begin
      ea_r <= cif.agAddr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flags word
  always_comb begin
    flagsNxt = flags_r;
    if (state_r == ST_PWT) begin
      flagsNxt[FLG_Z] = (dataRdData == 8'h00);
      flagsNxt[FLG_N] = dataRdData[7];
    end else if (cmdGo) begin
      unique case (cmdIn)
        CMD_ADD, CMD_SUB: begin
          flagsNxt[FLG_C] = cif.aluC;
          flagsNxt[FLG_H] = cif.aluH;
          flagsNxt[FLG_V] = cif.aluV;
          flagsNxt[FLG_Z] = cif.aluZ;
          flagsNxt[FLG_N] = cif.aluN;
        end
        CMD_SHL, CMD_ROL: begin
          flagsNxt[FLG_C] = cif.aluC;
          flagsNxt[FLG_Z] = cif.aluZ;
          flagsNxt[FLG_N] = cif.aluN;
        end
        CMD_LDA: begin
          flagsNxt[FLG_Z] = cif.aluZ;
          flagsNxt[FLG_N] = cif.aluN;
        end
        CMD_BIT: begin
          flagsNxt[FLG_Z] = cif.aluZ;
          flagsNxt[FLG_V] = cif.aluV;
          flagsNxt[FLG_N] = cif.aluN;
        end
        CMD_IRQ_ON: flagsNxt[FLG_I] = 1'b1;
        CMD_IRQ_OFF: flagsNxt[FLG_I] = 1'b0;
        CMD_IRQ: flagsNxt[FLG_I] = 1'b0;
        CMD_PAGE_ONE: flagsNxt[FLG_G] = 1'b1;
        CMD_PAGE_ZERO: flagsNxt[FLG_G] = 1'b0;
        CMD_OVF_CLEAR: begin
          flagsNxt[FLG_V] = 1'b0;
          flagsNxt[FLG_H] = 1'b0;
        end
        CMD_SW_BREAK: flagsNxt[FLG_B] = 1'b1;
        default: flagsNxt = flags_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_r <= FLAGS_RST;
    end else if (regWr && paddr == OFF_FLAGS) begin
      flags_r <= pwdata[7:0];
    end else begin
      flags_r <= flagsNxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_boot_vector: assert property (
    state_r == ST_BOOT |=> progRd_r && progAddr_r == RESET_VEC_LO
      ##1 progAddr_r == RESET_VEC_HI ##2 state_r == ST_IDLE)
    else $error("reset vector fetch out of order");
  a_vector_load: assert property (
    state_r == ST_FWT |=> pc_r == {$past(progRdData), $past(fetchLo_r)})
    else $error("program counter not loaded from vector");
  a_pair_incr: assert property (
    cmdGo && cmdIn == CMD_INCYA
      |=> wideAccPair == $past(wideAccPair) + 16'h0001)
    else $error("wide pair increment wrong");
  a_index_sum: assert property (
    cmdGo && cmdIn == CMD_IDXX
      |=> ea_r == $past(opnd_r) + {8'h00, $past(x_r)})
    else $error("indexed address wrong");
  a_push_order: assert property (
    cmdGo && cmdIn == CMD_PUSH |=> dataWr_r
      && dataAddr_r == {STACK_PAGE, $past(stackPtr_r)}
      && stackPtr_r == $past(stackPtr_r)
      ##1 !dataWr_r && stackPtr_r == $past(stackPtr_r, 2) - 8'h01)
    else $error("push order wrong");
  a_pop_order: assert property (
    cmdGo && cmdIn == CMD_POP |=> dataRd_r
      && stackPtr_r == $past(stackPtr_r) + 8'h01
      && dataAddr_r == {STACK_PAGE, stackPtr_r})
    else $error("pop order wrong");
  a_zero_load: assert property (
    cmdGo && cmdIn == CMD_LDA
      |=> flags_r[FLG_Z] == ($past(opLow) == 8'h00))
    else $error("zero flag wrong after transfer");
  a_irq_blocked: assert property (
    cmdGo && cmdIn == CMD_IRQ && !flags_r[FLG_I]
      |=> state_r == ST_IDLE && !progRd_r)
    else $error("masked interrupt was taken");
  a_irq_vector: assert property (
    cmdGo && irqTake |=> !flags_r[FLG_I] && progRd_r
      && progAddr_r == IRQ_VEC_BASE + {11'h000, $past(opSlot), 1'b0})
    else $error("interrupt vector slot wrong");
  a_page_direct: assert property (
    cmdGo && cmdIn == CMD_DIRECT
      |=> ea_r == {7'h00, $past(pageFlag), $past(opLow)})
    else $error("direct page address wrong");
  a_pc_wrap: assert property (
    cmdGo && cmdIn == CMD_INCPC && pc_r == PC_LAST |=> pc_r == PC_FIRST)
    else $error("program counter did not wrap");
  a_table_slot: assert property (
    cmdGo && cmdIn == CMD_TABLE_CALL
      |=> progAddr_r == TABLE_CALL_BASE + {11'h000, ~$past(opSlot), 1'b0})
    else $error("table call slot wrong");
endmodule

// ===== design/csav_core_if.sv
// signals between the core and its alu and address generator
`timescale 1ns/1ps
interface csav_core_if;
  import csav_pkg::*;
  csav_alu_op_t aluOp;
  logic [7:0] aluA, aluB, aluRes;
  logic aluCin, aluC, aluH, aluV, aluZ, aluN;
  csav_ag_mode_t agMode;
  logic [15:0] agOpnd, agAddr;
  logic [7:0] agX, agY;
  logic agPage;
  logic [3:0] agSlot;
  modport core (output aluOp, aluA, aluB, aluCin, agMode, agOpnd, agX, agY,
    agPage, agSlot, input aluRes, aluC, aluH, aluV, aluZ, aluN, agAddr);
  modport alu (input aluOp, aluA, aluB, aluCin,
    output aluRes, aluC, aluH, aluV, aluZ, aluN);
  modport agen (input agMode, agOpnd, agX, agY, agPage, agSlot,
    output agAddr);
endinterface

// ===== design/csav_pkg.sv
// constants, commands and register map of the cpu state block
package csav_pkg;
  // program memory map
  localparam logic [15:0] RESET_VEC_LO = 16'hfffe;
  localparam logic [15:0] RESET_VEC_HI = 16'hffff;
  localparam logic [15:0] TABLE_CALL_BASE = 16'hffc0;
  localparam logic [15:0] IRQ_VEC_BASE = 16'hffe0;
  localparam logic [7:0] PAGE_CALL_PAGE = 8'hff;
  localparam logic [3:0] SW_BREAK_SLOT = 4'h0;
  localparam logic [3:0] RESET_SLOT = 4'hf;
  localparam logic [15:0] PC_LAST = 16'hffff;
  localparam logic [15:0] PC_FIRST = 16'h0000;
  // data memory map
  localparam logic STACK_PAGE = 1'b1;
  // flag positions in cpu_flags_word
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_I = 2;
  localparam int FLG_H = 3;
  localparam int FLG_B = 4;
  localparam int FLG_G = 5;
  localparam int FLG_V = 6;
  localparam int FLG_N = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // apb byte offsets
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_X = 8'h04;
  localparam logic [7:0] OFF_Y = 8'h08;
  localparam logic [7:0] OFF_STACK_PTR = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_PC = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_OPND = 8'h1c;
  localparam logic [7:0] OFF_EA = 8'h20;
  localparam logic [7:0] OFF_WIDE_PAIR = 8'h24;
  typedef enum logic [4:0] {
    CMD_NOP = 5'h00, CMD_RSTV = 5'h01, CMD_ADD = 5'h02, CMD_SUB = 5'h03,
    CMD_SHL = 5'h04, CMD_ROL = 5'h05, CMD_LDA = 5'h06, CMD_BIT = 5'h07,
    CMD_PUSH = 5'h08, CMD_POP = 5'h09, CMD_IRQ_ON = 5'h0a,
    CMD_IRQ_OFF = 5'h0b, CMD_PAGE_ONE = 5'h0c, CMD_PAGE_ZERO = 5'h0d,
    CMD_OVF_CLEAR = 5'h0e, CMD_SW_BREAK = 5'h0f, CMD_TABLE_CALL = 5'h10,
    CMD_PAGE_CALL = 5'h11, CMD_IRQ = 5'h12, CMD_IDXX = 5'h13,
    CMD_IDXY = 5'h14, CMD_DIRECT = 5'h15, CMD_INCPC = 5'h16,
    CMD_INCYA = 5'h17
  } csav_cmd_t;
  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_SHL, ALU_ROL, ALU_PASS, ALU_BIT
  } csav_alu_op_t;
  typedef enum logic [2:0] {
    AG_IDX_X, AG_IDX_Y, AG_DIRECT, AG_TABLE, AG_VEC, AG_PAGE_CALL
  } csav_ag_mode_t;
endpackage

// ===== tb/csav_mem_model.sv
// program rom and data ram facing the cpu state block
`timescale 1ns/1ps
module csav_mem_model (
  input wire logic clk,
  input wire logic [15:0] progAddr,
  input wire logic progRd,
  output logic [7:0] progRdData,
  input wire logic [8:0] dataAddr,
  input wire logic dataRd,
  input wire logic dataWr,
  input wire logic [7:0] dataWrData,
  output logic [7:0] dataRdData
);
  logic [7:0] ram [512];
  function automatic logic [7:0] rom(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
  endfunction
  initial progRdData = 8'h00;
  initial dataRdData = 8'h00;
  // read-only store; data toggles whenever no read was asked for
  always @(posedge clk) begin
    progRdData <= progRd ? rom(progAddr) : ~progRdData;
  end
  always @(posedge clk) begin
    if (dataWr) ram[dataAddr] <= dataWrData;
    dataRdData <= dataRd ? ram[dataAddr] : ~dataRdData;
  end
endmodule

// ===== tb/tb.sv
// self-checking bench for the cpu state block
`timescale 1ns/1ps
module tb;
  import csav_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, progRd, dataRd, dataWr;
  logic [15:0] progAddr;
  logic [7:0] progRdData, dataWrData, dataRdData;
  logic [8:0] dataAddr;
  logic [32:0] expQ[$];
  int error_cnt = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  csav_core dut (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .progAddr(progAddr),
    .progRd(progRd), .progRdData(progRdData), .dataAddr(dataAddr),
    .dataRd(dataRd), .dataWr(dataWr), .dataWrData(dataWrData),
    .dataRdData(dataRdData));
  csav_mem_model mem (.clk(clk), .progAddr(progAddr), .progRd(progRd),
    .progRdData(progRdData), .dataAddr(dataAddr), .dataRd(dataRd),
    .dataWr(dataWr), .dataWrData(dataWrData), .dataRdData(dataRdData));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task end_of_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // each completed transfer is matched with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && expQ.size() > 0) begin
      chk(expQ.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    end
  end
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] d, input logic [32:0] e);
    expQ.push_back(e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b0, 32'h0, {1'b0, d});
  endtask
  task automatic cmd(input csav_cmd_t c, input logic [15:0] o);
    wr(OFF_OPND, {16'h0, o});
    wr(OFF_CMD, {27'h0, c});
    repeat (6) @(posedge clk);
  endtask
  function automatic logic [31:0] vec(input logic [15:0] v);
    return {16'h0, mem.rom(v + 16'h1), mem.rom(v)};
  endfunction
  // expected {result, flags word} of one alu command
  function automatic logic [15:0] alu(input int op, input logic [7:0] a,
    input logic [7:0] b, input logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic cc, hh, v;
    cc = c;
    hh = 1'b0;
    v = 1'b0;
    r = b;
    s = 9'h0;
    h = 5'h0;
    case (op)
      0: begin
        s = {1'b0, a} + {1'b0, b} + {8'h0, c};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        r = s[7:0];
        cc = s[8];
        hh = h[4];
        v = (a[7] == b[7]) && (r[7] != a[7]);
      end
      1: begin
        s = {1'b0, a} - {1'b0, b} - {8'h0, !c};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, !c};
        r = s[7:0];
        cc = !s[8];
        hh = !h[4];
        v = (a[7] != b[7]) && (r[7] != a[7]);
      end
      2: begin
        r = {a[6:0], 1'b0};
        cc = a[7];
      end
      3: begin
        r = {a[6:0], c};
        cc = a[7];
      end
      4: return {a, b[7], b[6], 4'h0, (a & b) == 8'h0, c};
      default: r = b;
    endcase
    return {r, r[7], v, 2'b00, hh, 1'b0, r == 8'h0, cc};
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    logic [7:0] a, b;
    logic c;
    logic [15:0] e;
    static csav_cmd_t ops[6] = '{CMD_ADD, CMD_SUB, CMD_SHL, CMD_ROL,
      CMD_BIT, CMD_LDA};
    static csav_cmd_t fc[7] = '{CMD_IRQ_ON, CMD_IRQ_OFF, CMD_PAGE_ONE,
      CMD_PAGE_ZERO, CMD_OVF_CLEAR, CMD_SW_BREAK, CMD_IRQ};
    static logic [7:0] fp[7] = '{8'h00, 8'h04, 8'h00, 8'h20, 8'h48,
      8'h00, 8'h04};
    static logic [7:0] fe[7] = '{8'h04, 8'h00, 8'h20, 8'h00, 8'h00,
      8'h10, 8'h00};
    static csav_cmd_t vc[7] = '{CMD_TABLE_CALL, CMD_TABLE_CALL,
      CMD_TABLE_CALL, CMD_SW_BREAK, CMD_IRQ, CMD_IRQ, CMD_RSTV};
    static logic [15:0] vo[7] = '{16'hf, 16'he, 16'h0, 16'h0, 16'h0,
      16'he, 16'h0};
    static logic [15:0] va[7] = '{16'hffc0, 16'hffc2, 16'hffde, 16'hffde,
      16'hffe0, 16'hfffc, 16'hfffe};
    void'($urandom(32'h018d));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFF_PC, vec(16'hfffe));
    rd(OFF_FLAGS, 32'h0);
    xfer(8'h28, 1'b0, 32'h0, {1'b1, 32'h0});
    xfer(8'h02, 1'b0, 32'h0, {1'b1, 32'h0});
    xfer(OFF_EA, 1'b1, 32'h1, {1'b1, 32'h0});
    for (int i = 0; i < 24; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      c = 1'($urandom);
      e = alu(i % 6, a, b, c);
      wr(OFF_ACC, {24'h0, a});
      wr(OFF_FLAGS, {31'h0, c});
      cmd(ops[i % 6], {8'h0, b});
      rd(OFF_ACC, {24'h0, e[15:8]});
      rd(OFF_FLAGS, {24'h0, e[7:0]});
    end
    for (int i = 0; i < 7; i++) begin
      wr(OFF_FLAGS, {24'h0, fp[i]});
      cmd(fc[i], 16'h0);
      rd(OFF_FLAGS, {24'h0, fe[i]});
      wr(OFF_FLAGS, 32'h04);
      cmd(vc[i], vo[i]);
      rd(OFF_PC, vec(va[i]));
    end
    wr(OFF_PC, 32'h1234);
    wr(OFF_FLAGS, 32'h0);
    cmd(CMD_IRQ, 16'h5);
    rd(OFF_PC, 32'h1234);
    cmd(CMD_PAGE_CALL, 16'h35);
    rd(OFF_PC, 32'hff35);
    wr(OFF_PC, 32'hffff);
    cmd(CMD_INCPC, 16'h0);
    rd(OFF_PC, 32'h0);
    wr(OFF_ACC, 32'hff);
    wr(OFF_Y, 32'h12);
    cmd(CMD_INCYA, 16'h0);
    rd(OFF_WIDE_PAIR, 32'h1300);
    wr(OFF_X, 32'h10);
    cmd(CMD_IDXX, 16'h1ff0);
    rd(OFF_EA, 32'h2000);
    cmd(CMD_IDXY, 16'h0010);
    rd(OFF_EA, 32'h0023);
    wr(OFF_FLAGS, 32'h20);
    cmd(CMD_DIRECT, 16'h1a35);
    rd(OFF_EA, 32'h0135);
    wr(OFF_FLAGS, 32'h0);
    cmd(CMD_DIRECT, 16'h1a35);
    rd(OFF_EA, 32'h0035);
    wr(OFF_STACK_PTR, 32'hff);
    wr(OFF_ACC, 32'h3c);
    cmd(CMD_PUSH, 16'h0);
    rd(OFF_STACK_PTR, 32'hfe);
    chk({25'h0, 8'h3c}, {25'h0, mem.ram[9'h1ff]});
    wr(OFF_ACC, 32'h0);
    cmd(CMD_POP, 16'h0);
    rd(OFF_ACC, 32'h3c);
    rd(OFF_STACK_PTR, 32'hff);
    wr(OFF_OPND, 32'h0);
    wr(OFF_CMD, {27'h0, CMD_RSTV});
    xfer(OFF_ACC, 1'b1, 32'h5, {1'b1, 32'h0});
    repeat (6) @(posedge clk);
    rd(OFF_ACC, 32'h3c);
    end_of_test;
  end
endmodule
